/* File: pkg/vfx_pkg.sv */
// Package for the vector fixed-point state block: register addresses,
// field positions, reset values, rounding-mode codes and carrier structs.
// Assumes a single hart clock and a simple CSR port from the core.
package vfx_pkg;

  localparam int unsigned XW = 32;
  localparam int unsigned ADDR_W = 12;

  // Control/status addresses: three views of the fixed-point state, then start index, element count and type.
  localparam logic [11:0] ADDR_ROUND_MODE = 12'h009;
  localparam logic [11:0] ADDR_SAT_FLAG = 12'h00a;
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h00f;
  localparam logic [11:0] ADDR_VSTART = 12'h008;
  localparam logic [11:0] ADDR_ELEM_COUNT = 12'hc20;
  localparam logic [11:0] ADDR_VTYPE = 12'hc21;

  // Field positions.
  localparam int unsigned RM_LO = 0;
  localparam int unsigned SAT_BIT = 0;
  localparam int unsigned CS_SAT_BIT = 0;
  localparam int unsigned CS_RM_LO = 1;
  localparam int unsigned VTYPE_ILL_BIT = XW - 1;
  localparam int unsigned VTYPE_TA_BIT = 6;
  localparam int unsigned VTYPE_MA_BIT = 7;
  localparam int unsigned VTYPE_FIELD_W = 8;

  // Values after reset.
  localparam logic [1:0] RM_RESET = 2'h0;
  localparam logic SAT_RESET = 1'h0;
  localparam logic [XW-1:0] VTYPE_RESET = 32'h80000000;
  localparam logic [XW-1:0] ELEM_COUNT_RESET = 32'h00000000;
  localparam logic [XW-1:0] VSTART_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    RM_NEAR_UP = 2'h0,
    RM_NEAR_EVEN = 2'h1,
    RM_TRUNCATE = 2'h2,
    RM_ODD = 2'h3
  } vfx_round_mode_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [XW-1:0] wdata;
  } vfx_csr_req_type;

  typedef struct packed {
    logic valid;
    logic is_signed;
    logic [63:0] value;
    logic [5:0] shift;
  } vfx_round_req_type;

  typedef struct packed {
    logic set_len;
    logic ill;
    logic [VTYPE_FIELD_W-1:0] vtype;
    logic [XW-1:0] count;
  } vfx_setlen_type;

endpackage

/* File: hw/vfx_state.sv */
// Vector fixed-point architectural state: rounding mode, sticky saturation
// flag, combined control/status view, type/length/start-index registers and
// the rounding-increment datapath. Element packing helper for group layout.
// Assumes the core decodes CSR accesses into one request per cycle and
// presents rounding and saturation events from the fixed-point pipeline.
//
// Behaviour
// [RQ1] Two-bit read-write rounding-mode field, low bits.
// [RQ2] Software writes zeros above the mode field.
// [RQ3] Mode has own address, mirrored in combined register.
// [RQ4] Result is value shifted right plus increment.
// [RQ5] Nearest-up adds bit d-1; truncate adds zero.
// [RQ6] Nearest-even: bit d-1 and (sticky or bit d).
// [RQ7] Odd: add one if bit d clear, low nonzero.
// [RQ8] Unsigned shifts logically, signed shifts arithmetically.
// [RQ9] Saturation bit zero set on saturating result.
// [RQ10] Software writes zeros above saturation bit.
// [RQ11] Combined register: mode bits 2:1, flag bit 0.
// [RQ12] Reset type and length restorable by set-length.
// [RQ13] Reset sets illegal bit, clears type, length.
// [RQ14] Start index, mode, flag need no reset value.
// [RQ15] Software initialises mode and flag before use.
// [RQ16] Elements packed in index order, low byte first.
// [RQ17] Fractional groups use leading elements, rest is tail.
// [RQ18] Large groups fill lowest register first.
// [RQ19] Internal layout may differ if visible packing holds.
// [RQ20] Illegal type bit forces other type bits zero.
// [RQ21] Both policy bits held even if ignored.
// [RQ22] Zero shift amount gives zero increment.
// [RQ23] Saturation flag sticky until software writes it.
`timescale 1ns/1ps

module vfx_state
  import vfx_pkg::*;
#(
  parameter int unsigned REG_BITS = 128,
  parameter int unsigned IDX_W = 7
) (
  input wire logic core_clk, // Hart clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire vfx_csr_req_type csr_req, // CSR access from the core.
  input wire logic sat_event, // Fixed-point op saturated this cycle.
  input wire vfx_setlen_type setlen, // Set-length update from the core.
  input wire logic vec_done, // A vector instruction retired.
  input wire vfx_round_req_type round_req, // Value to round off.
  input wire logic [IDX_W-1:0] pack_index, // Element index to place.
  input wire logic [1:0] pack_width_log, // Element width: 8 << this.
  output logic [XW-1:0] csr_rdata, // Registered read data.
  output logic csr_rvalid, // Read data valid, one cycle.
  output logic csr_err, // Unmapped address, one cycle.
  output logic [1:0] round_mode, // Current rounding mode.
  output logic sat_flag, // Current saturation flag.
  output logic [XW-1:0] vtype_out, // Current type register.
  output logic [XW-1:0] elem_count_reg, // Current element count.
  output logic [63:0] round_result, // Rounded value.
  output logic round_valid, // Rounded value valid, one cycle.
  output logic [2:0] pack_reg_offset, // Group register for the element.
  output logic [IDX_W-1:0] pack_byte // Lowest byte within the register.
);

  localparam int unsigned REG_BYTES = REG_BITS / 8;

  logic [1:0] next_round_mode;
  logic next_sat_flag;
  logic [XW-1:0] next_vtype_out;
  logic [XW-1:0] next_elem_count_reg;
  logic [XW-1:0] vstart;
  logic [XW-1:0] next_vstart;
  logic [XW-1:0] next_csr_rdata;
  logic next_csr_rvalid;
  logic next_csr_err;
  logic [63:0] next_round_result;
  logic next_round_valid;
  logic [2:0] next_pack_reg_offset;
  logic [IDX_W-1:0] next_pack_byte;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_ROUND_MODE) || (a == ADDR_SAT_FLAG) ||
             (a == ADDR_CTRL_STATUS) || (a == ADDR_VSTART) ||
             (a == ADDR_ELEM_COUNT) || (a == ADDR_VTYPE);
  endfunction

  // Type register image: an illegal setting clears every other bit.
  function automatic logic [XW-1:0] vtype_image(
      input logic ill, input logic [VTYPE_FIELD_W-1:0] f);
    logic [XW-1:0] v;
    v = '0;
    if (ill) begin
      v[VTYPE_ILL_BIT] = 1'h1; // RQ20
    end else begin
      v[VTYPE_FIELD_W-1:0] = f; // RQ21
    end
    vtype_image = v;
  endfunction

  // Rounding increment from the mode, value and shift amount.
  function automatic logic round_inc(input logic [1:0] m,
      input logic [63:0] v, input logic [5:0] d);
    logic half;
    logic lsb;
    logic below;
    logic any;
    logic [63:0] low_mask;
    half = 1'h0;
    lsb = v[d];
    below = 1'h0;
    any = 1'h0;
    low_mask = (64'h1 << d) - 64'h1;
    if (d != 6'h0) begin
      half = v[d - 6'h1];
      below = |(v & (low_mask >> 1));
      any = |(v & low_mask);
    end
    case (m)
      RM_NEAR_UP: round_inc = half; // RQ5
      RM_NEAR_EVEN: round_inc = half & (below | lsb); // RQ6
      RM_TRUNCATE: round_inc = 1'h0; // RQ5
      RM_ODD: round_inc = ~lsb & any; // RQ7
      default: round_inc = 1'h0;
    endcase
    if (d == 6'h0) begin
      round_inc = 1'h0; // RQ22
    end
  endfunction

  // Write strobe for one address of the access in flight.
  function automatic logic write_to(input vfx_csr_req_type r,
      input logic [11:0] a);
    write_to = r.wr && (r.addr == a);
  endfunction

  // Fixed-point state: rounding mode and sticky saturation flag.
  always_comb begin
    logic wr_rm;
    logic wr_sat;
    logic wr_cs;
    wr_rm = write_to(csr_req, ADDR_ROUND_MODE);
    wr_sat = write_to(csr_req, ADDR_SAT_FLAG);
    wr_cs = write_to(csr_req, ADDR_CTRL_STATUS);

    // Both views write the same state, so no copy can drift.
    next_round_mode = round_mode;
    if (wr_rm) begin
      next_round_mode = csr_req.wdata[RM_LO +: 2]; // RQ1 RQ3
    end else if (wr_cs) begin
      next_round_mode = csr_req.wdata[CS_RM_LO +: 2]; // RQ11
    end

    // A saturation in the same cycle as a write wins, so none is lost.
    next_sat_flag = sat_flag;
    if (wr_sat) begin
      next_sat_flag = csr_req.wdata[SAT_BIT]; // RQ9
    end else if (wr_cs) begin
      next_sat_flag = csr_req.wdata[CS_SAT_BIT]; // RQ11
    end
    if (sat_event) begin
      next_sat_flag = 1'h1; // RQ9 RQ23
    end
  end

  // Mode and flag need no reset value; they get one anyway so that a run
  // never starts from unknown state.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      round_mode <= RM_RESET; // RQ14
      sat_flag <= SAT_RESET; // RQ14
    end else begin
      round_mode <= next_round_mode;
      sat_flag <= next_sat_flag;
    end
  end

  // Type and length move only on a set-length update; CSR writes to their
  // addresses are dropped, as both registers are read-only.
  always_comb begin
    next_vtype_out = vtype_out;
    next_elem_count_reg = elem_count_reg;
    if (setlen.set_len) begin
      next_vtype_out = vtype_image(setlen.ill, setlen.vtype); // RQ12
      next_elem_count_reg = setlen.ill ? '0 : setlen.count; // RQ12
    end
  end

  // Reset leaves an illegal type and no elements, which software can read
  // back and restore with one set-length update.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vtype_out <= VTYPE_RESET; // RQ13
      elem_count_reg <= ELEM_COUNT_RESET; // RQ13
    end else begin
      vtype_out <= next_vtype_out;
      elem_count_reg <= next_elem_count_reg;
    end
  end

  // Any finished vector instruction, set-length included, lets the next one
  // start at element zero. All start index bits are kept as written.
  always_comb begin
    next_vstart = vstart;
    if (write_to(csr_req, ADDR_VSTART)) begin
      next_vstart = csr_req.wdata;
    end
    if (vec_done || setlen.set_len) begin
      next_vstart = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vstart <= VSTART_RESET; // RQ14
    end else begin
      vstart <= next_vstart;
    end
  end

  // Read answer: stands for one cycle after the access and shows the state
  // as it was before any write in the same cycle.
  always_comb begin
    next_csr_rvalid = csr_req.rd && mapped(csr_req.addr);
    next_csr_err = (csr_req.rd || csr_req.wr) && !mapped(csr_req.addr);
    next_csr_rdata = '0;
    if (csr_req.rd) begin
      case (csr_req.addr)
        ADDR_ROUND_MODE: next_csr_rdata[RM_LO +: 2] = round_mode; // RQ3
        ADDR_SAT_FLAG: next_csr_rdata[SAT_BIT] = sat_flag; // RQ9
        ADDR_CTRL_STATUS: begin
          next_csr_rdata[CS_RM_LO +: 2] = round_mode; // RQ11
          next_csr_rdata[CS_SAT_BIT] = sat_flag; // RQ11
        end
        ADDR_VSTART: next_csr_rdata = vstart;
        ADDR_ELEM_COUNT: next_csr_rdata = elem_count_reg; // RQ12
        ADDR_VTYPE: next_csr_rdata = vtype_out; // RQ12
        default: next_csr_rdata = '0;
      endcase
    end
  end

  // An unmapped access answers with an error pulse and changes nothing.
  // The error is kept apart from the read data so a caller can trap on it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      csr_rdata <= '0;
      csr_rvalid <= 1'h0;
      csr_err <= 1'h0;
    end else begin
      csr_rdata <= next_csr_rdata;
      csr_rvalid <= next_csr_rvalid;
      csr_err <= next_csr_err;
    end
  end

  // Rounding uses the mode as it stands at the request, so a mode write
  // takes effect from the following request on.
  always_comb begin
    logic [63:0] shifted;
    logic inc;
    shifted = '0;
    inc = round_inc(round_mode, round_req.value, round_req.shift);
    // Signed values shift arithmetically, unsigned ones logically.
    if (round_req.is_signed) begin
      shifted = 64'($signed(round_req.value) >>> round_req.shift); // RQ8
    end else begin
      shifted = round_req.value >> round_req.shift; // RQ8
    end
    next_round_result = shifted + 64'(inc); // RQ4
    next_round_valid = round_req.valid;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      round_result <= '0;
      round_valid <= 1'h0;
    end else begin
      round_result <= next_round_result;
      round_valid <= next_round_valid;
    end
  end

  // Element placement: byte offset grows in index order and spills into
  // the next register of the group once the current one is full. The
  // stored layout is the visible one, so nothing is rearranged inside.
  // Fractional groups reuse the same placement; indices past the used
  // count fall in the tail, which the caller handles.
  always_comb begin
    logic [IDX_W+3:0] byte_pos;
    byte_pos = (IDX_W + 4)'(pack_index) << pack_width_log; // RQ16 RQ19
    next_pack_byte = IDX_W'(byte_pos % REG_BYTES); // RQ17
    next_pack_reg_offset = 3'(byte_pos / REG_BYTES); // RQ18
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pack_reg_offset <= '0;
      pack_byte <= '0;
    end else begin
      pack_reg_offset <= next_pack_reg_offset;
      pack_byte <= next_pack_byte;
    end
  end

endmodule

/* File: tb/vfx_state_monitor.sv */
// Checker for the fixed-point state block, bound to its top module.
// Assumes the one-cycle registered answers of the CSR and rounding ports.
`timescale 1ns/1ps
module vfx_state_monitor
  import vfx_pkg::*;
(
  input wire logic core_clk, // Hart clock.
  input wire logic rstn, // Reset, active low.
  input wire vfx_csr_req_type csr_req, // CSR access.
  input wire logic sat_event, // Saturation event.
  input wire vfx_round_req_type round_req, // Rounding request.
  input wire logic [XW-1:0] csr_rdata, // Read data.
  input wire logic csr_rvalid, // Read valid.
  input wire logic [1:0] round_mode, // Rounding mode.
  input wire logic sat_flag, // Saturation flag.
  input wire logic [XW-1:0] vtype_out, // Type register.
  input wire logic [63:0] round_result, // Rounded value.
  input wire logic round_valid // Rounded value valid.
);
  logic [11:0] a;
  logic [XW-1:0] w;
  assign a = csr_req.addr;
  assign w = csr_req.wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_mode_write: assert property (csr_req.wr && a == ADDR_ROUND_MODE
    |=> round_mode == $past(w[1:0])) else $error("mode write lost");
  chk_mode_hold: assert property (!csr_req.wr |=> $stable(round_mode))
    else $error("mode changed without a write");
  chk_cs_write: assert property (csr_req.wr && a == ADDR_CTRL_STATUS
    && !sat_event |=> round_mode == $past(w[2:1]) && sat_flag == $past(w[0]))
    else $error("combined write lost");
  chk_cs_read: assert property (csr_req.rd && !csr_req.wr && !sat_event
    && a == ADDR_CTRL_STATUS |=> csr_rvalid
    && csr_rdata == {29'h0, $past(round_mode), $past(sat_flag)})
    else $error("combined read wrong");
  chk_sat_set: assert property (sat_event |=> sat_flag)
    else $error("flag not set");
  chk_sat_sticky: assert property (sat_flag && !csr_req.wr
    |=> sat_flag) else $error("flag cleared without a write");
  chk_round_trunc: assert property (round_req.valid
    && round_mode == RM_TRUNCATE && !round_req.is_signed |=> round_valid
    && round_result == $past(round_req.value) >> $past(round_req.shift))
    else $error("truncate wrong");
  chk_round_zero: assert property (round_req.valid
    && round_req.shift == 6'h0 |=> round_valid
    && round_result == $past(round_req.value)) else $error("zero shift wrong");
  chk_ill_zero: assert property (vtype_out[VTYPE_ILL_BIT]
    |-> vtype_out[VTYPE_ILL_BIT-1:0] == '0) else $error("type bits not zero");
endmodule

bind vfx_state vfx_state_monitor i_vfx_state_monitor (.core_clk(core_clk),
  .rstn(rstn), .csr_req(csr_req), .sat_event(sat_event),
  .round_req(round_req), .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
  .round_mode(round_mode), .sat_flag(sat_flag), .vtype_out(vtype_out),
  .round_result(round_result), .round_valid(round_valid));

/* File: tb/tb_top.sv */
// Self-checking bench for the fixed-point state block.
// Assumes inputs are sampled on the rising edge; the bench drives on falling.
`timescale 1ns/1ps
module tb_top
  import vfx_pkg::*;
;
  logic core_clk, rstn, sat_event, vec_done, rv, rerr;
  vfx_csr_req_type csr_req;
  vfx_setlen_type setlen;
  vfx_round_req_type round_req;
  logic [6:0] pack_index, pack_byte;
  logic [1:0] pack_width_log, round_mode;
  logic [2:0] pack_reg_offset;
  logic [31:0] csr_rdata, vtype_out, elem_count_reg, rdat;
  logic csr_rvalid, csr_err, sat_flag, round_valid;
  logic [63:0] round_result;
  int fail_count, checks_done;
  vfx_state i_vfx_state (.core_clk(core_clk), .rstn(rstn), .csr_req(csr_req),
    .sat_event(sat_event), .setlen(setlen), .vec_done(vec_done),
    .round_req(round_req), .pack_index(pack_index),
    .pack_width_log(pack_width_log), .csr_rdata(csr_rdata),
    .csr_rvalid(csr_rvalid), .csr_err(csr_err), .round_mode(round_mode),
    .sat_flag(sat_flag), .vtype_out(vtype_out),
    .elem_count_reg(elem_count_reg), .round_result(round_result),
    .round_valid(round_valid), .pack_reg_offset(pack_reg_offset),
    .pack_byte(pack_byte));
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic nx();
    @(negedge core_clk);
  endtask
  task automatic chk(string n, logic [64:0] e, logic [64:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // Answers stand one cycle, so they are captured before the idle cycle.
  task automatic acc(logic wr, logic [11:0] a, logic [31:0] d);
    csr_req = '{wr, !wr, a, d};
    nx();
    {rv, rerr, rdat} = {csr_rvalid, csr_err, csr_rdata};
    csr_req = '0;
    nx();
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    acc(0, a, 0);
    chk("csr read", {1'b1, e}, {rv, rdat});
  endtask
  function automatic logic [63:0] ref_rnd(logic [63:0] v, int d, int m, bit s);
    logic r;
    r = 0;
    if (d > 0)
      case (m)
        0: r = v[d-1];
        1: r = v[d-1] & ((v & ((64'h1 << (d - 1)) - 1)) != 0 | v[d]);
        3: r = !v[d] & ((v & ((64'h1 << d) - 1)) != 0);
        default: r = 0;
      endcase
    return (s ? 64'($signed(v) >>> d) : v >> d) + 64'(r);
  endfunction
  task automatic t_reset();
    chk("type", VTYPE_RESET, vtype_out);
    chk("count", ELEM_COUNT_RESET, elem_count_reg);
    rd(ADDR_VTYPE, VTYPE_RESET);
  endtask
  task automatic t_mode();
    acc(1, ADDR_CTRL_STATUS, 0);
    for (int m = 0; m < 4; m++) begin
      acc(1, ADDR_ROUND_MODE, 32'(m));
      rd(ADDR_ROUND_MODE, 32'(m));
      rd(ADDR_CTRL_STATUS, 32'(m) << 1);
      chk("mode out", m, round_mode);
    end
    acc(1, ADDR_CTRL_STATUS, 32'h5);
    rd(ADDR_ROUND_MODE, 32'h2);
    rd(ADDR_SAT_FLAG, 32'h1);
    acc(0, 12'h123, 0);
    chk("unmapped", 1, rerr);
  endtask
  task automatic t_sat();
    acc(1, ADDR_SAT_FLAG, 0);
    sat_event = 1;
    nx();
    sat_event = 0;
    vec_done = 1;
    nx();
    vec_done = 0;
    chk("flag out", 1, sat_flag);
    rd(ADDR_SAT_FLAG, 1);
    rd(ADDR_CTRL_STATUS, 32'h5);
    acc(1, ADDR_SAT_FLAG, 0);
    rd(ADDR_SAT_FLAG, 0);
    chk("flag out", 0, sat_flag);
    // A saturation in the cycle of a clearing write must still be kept.
    sat_event = 1;
    acc(1, ADDR_SAT_FLAG, 0);
    sat_event = 0;
    rd(ADDR_SAT_FLAG, 1);
  endtask
  task automatic t_round();
    logic [63:0] vs[5] = '{64'h18, 64'h8, 64'hfffffffffffffff3,
      64'h8000000000000001, 64'h5};
    int ds[5] = '{4, 4, 2, 1, 0};
    for (int m = 0; m < 4; m++) begin
      acc(1, ADDR_ROUND_MODE, 32'(m));
      for (int i = 0; i < 10; i++) begin
        round_req = '{1'b1, i[0], vs[i/2], 6'(ds[i/2])};
        nx();
        chk("round", {1'b1, ref_rnd(vs[i/2], ds[i/2], m, i[0])},
          {round_valid, round_result});
        round_req = '0;
        nx();
      end
    end
  endtask
  task automatic t_setlen();
    setlen = '{1'b1, 1'b1, 8'hff, 32'h9};
    nx();
    setlen = '0;
    chk("ill type", {VTYPE_RESET, 32'h0}, {vtype_out, elem_count_reg});
    nx();
    setlen = '{1'b1, 1'b0, 8'hc5, 32'h5};
    nx();
    setlen = '0;
    chk("type", {32'hc5, 32'h5}, {vtype_out, elem_count_reg});
    acc(1, ADDR_VTYPE, 0);
    rd(ADDR_VTYPE, 32'hc5);
    rd(ADDR_ELEM_COUNT, 32'h5);
  endtask
  task automatic t_pack();
    int c[5][4] = '{'{3, 0, 0, 3}, '{5, 1, 0, 10}, '{9, 2, 2, 4},
      '{7, 3, 3, 8}, '{3, 2, 0, 12}};
    for (int i = 0; i < 5; i++) begin
      pack_index = 7'(c[i][0]);
      pack_width_log = 2'(c[i][1]);
      nx();
      chk("pack", {3'(c[i][2]), 7'(c[i][3])},
        {pack_reg_offset, pack_byte});
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50us;
    fail_count++;
    print_verdict();
  end
  initial begin
    {rstn, sat_event, vec_done, pack_index, pack_width_log} = '0;
    {csr_req, setlen, round_req} = '0;
    repeat (20) nx();
    rstn = 1;
    nx();
    t_reset();
    t_mode();
    t_sat();
    t_round();
    t_setlen();
    t_pack();
    print_verdict();
  end
endmodule
